// >>> logic/pwmirq_loop_if.sv
// signals between the register block and the loop completion tracker
`timescale 1ns/1ps
interface pwmirq_loop_if #(
    parameter int LOOP_W = 16
);
    logic start;
    logic seq1_end;
    logic [LOOP_W-1:0] loop_cnt;
    logic loops_done;

    modport tracker (
        input start,
        input seq1_end,
        input loop_cnt,
        output loops_done
    );

    modport owner (
        output start,
        output seq1_end,
        output loop_cnt,
        input loops_done
    );
endinterface

// >>> logic/pwmirq_loop_tracker.sv
// tracks loop playback and pulses when the sequence-one completion that ends the last loop of the playback is seen
`timescale 1ns/1ps
`include "pwmirq_regs.svh"
module pwmirq_loop_tracker #(
    parameter int LOOP_W = 16
) (
    input wire logic ref_clk_i,          // block clock
    input wire logic rstn_i,             // synchronous reset, active low
    pwmirq_loop_if.tracker lp            // playback start, loop count, completions
);
    logic [LOOP_W-1:0] remain_ff;
    logic done_ff;

    always_ff @(posedge ref_clk_i) begin
        if (!rstn_i) begin
            remain_ff <= LOOP_W'(`PWMIRQ_LOOP_RESET);
        end else if (lp.start) begin
            // a zero count at start leaves the tracker idle for this playback
            remain_ff <= lp.loop_cnt;
        end else if (lp.seq1_end && remain_ff != '0) begin
            remain_ff <= remain_ff - LOOP_W'(1);
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rstn_i) begin
            done_ff <= 1'b0;
        end else begin
            done_ff <= !lp.start && lp.seq1_end && remain_ff == LOOP_W'(1);
        end
    end

    assign lp.loops_done = done_ff;
endmodule

// >>> logic/pwmirq_pkg.sv
// types shared by the pwm interrupt enable block
package pwmirq_pkg;

    // register selected by an address
    typedef enum logic [5:0] {
        PWMIRQ_SEL_NONE = 6'h01,
        PWMIRQ_SEL_DIRECT = 6'h02,
        PWMIRQ_SEL_SET = 6'h04,
        PWMIRQ_SEL_CLEAR = 6'h08,
        PWMIRQ_SEL_STATUS = 6'h10,
        PWMIRQ_SEL_EVCLR = 6'h20
    } pwmirq_sel_type;

    // read channel sequencing
    typedef enum logic [1:0] {
        PWMIRQ_RD_IDLE = 2'h1,
        PWMIRQ_RD_RESP = 2'h2
    } pwmirq_rd_state_type;

    // write channel sequencing
    typedef enum logic [2:0] {
        PWMIRQ_WR_COLLECT = 3'h1,
        PWMIRQ_WR_APPLY = 3'h2,
        PWMIRQ_WR_RESP = 3'h4
    } pwmirq_wr_state_type;

endpackage

// >>> logic/pwmirq_regs.svh
// register offsets, field positions and reset values of the pwm interrupt enable block
`ifndef PWMIRQ_REGS_SVH
`define PWMIRQ_REGS_SVH

`define PWMIRQ_ADDR_W 12
`define PWMIRQ_OFS_ENABLE_DIRECT 12'h300
`define PWMIRQ_OFS_ENABLE_SET 12'h304
`define PWMIRQ_OFS_ENABLE_CLEAR 12'h308
`define PWMIRQ_OFS_EVENT_STATUS 12'h310
`define PWMIRQ_OFS_EVENT_CLEAR 12'h314

`define PWMIRQ_BIT_STOPPED 1
`define PWMIRQ_BIT_SEQ_BEGAN0 2
`define PWMIRQ_BIT_SEQ_BEGAN1 3
`define PWMIRQ_BIT_SEQ_FINISHED0 4
`define PWMIRQ_BIT_SEQ_FINISHED1 5
`define PWMIRQ_BIT_PERIOD_FINISHED 6
`define PWMIRQ_BIT_LOOPS_FINISHED 7
`define PWMIRQ_EVT_W 8
`define PWMIRQ_EVT_MASK 8'hFE

`define PWMIRQ_ENABLE_RESET 8'h00
`define PWMIRQ_STATUS_RESET 8'h00
`define PWMIRQ_LOOP_RESET 16'h0000

`define PWMIRQ_RESP_OKAY 2'h0
`define PWMIRQ_RESP_SLVERR 2'h2

`endif

// >>> logic/pwmirq_top.sv
// interrupt enable registers of the pulse-width generator with an axi4-lite slave
//
// Chosen here: register access over AXI4-Lite.
`timescale 1ns/1ps
`include "pwmirq_regs.svh"
module pwmirq_top #(
    parameter int LOOP_W = 16
) (
    input wire logic ref_clk_i,              // block clock, 25 MHz
    input wire logic rstn_i,                 // synchronous reset, active low
    input wire logic [11:0] s_axi_awaddr_i,  // write address
    input wire logic s_axi_awvalid_i,        // write address valid
    output logic s_axi_awready_o,            // write address ready
    input wire logic [31:0] s_axi_wdata_i,   // write data
    input wire logic [3:0] s_axi_wstrb_i,    // write byte strobes
    input wire logic s_axi_wvalid_i,         // write data valid
    output logic s_axi_wready_o,             // write data ready
    output logic [1:0] s_axi_bresp_o,        // write response
    output logic s_axi_bvalid_o,             // write response valid
    input wire logic s_axi_bready_i,         // write response ready
    input wire logic [11:0] s_axi_araddr_i,  // read address
    input wire logic s_axi_arvalid_i,        // read address valid
    output logic s_axi_arready_o,            // read address ready
    output logic [31:0] s_axi_rdata_o,       // read data
    output logic [1:0] s_axi_rresp_o,        // read response
    output logic s_axi_rvalid_o,             // read data valid
    input wire logic s_axi_rready_i,         // read data ready
    input wire logic stopped_i,              // stop event pulse
    input wire logic [1:0] seq_began_i,      // sequence began event pulses
    input wire logic [1:0] seq_finished_i,   // sequence finished event pulses
    input wire logic period_finished_i,      // period finished event pulse
    input wire logic playback_start_i,       // playback start pulse
    input wire logic [LOOP_W-1:0] loop_count_i, // loop count in force at start
    output logic [7:0] irq_enable_o,         // current enable bits
    output logic irq_o                       // interrupt request, level
);
    localparam int EW = `PWMIRQ_EVT_W;

    function automatic pwmirq_pkg::pwmirq_sel_type decode(input logic [11:0] addr);
        unique case ({addr[11:2], 2'h0})
            `PWMIRQ_OFS_ENABLE_DIRECT: decode = pwmirq_pkg::PWMIRQ_SEL_DIRECT;
            `PWMIRQ_OFS_ENABLE_SET: decode = pwmirq_pkg::PWMIRQ_SEL_SET;
            `PWMIRQ_OFS_ENABLE_CLEAR: decode = pwmirq_pkg::PWMIRQ_SEL_CLEAR;
            `PWMIRQ_OFS_EVENT_STATUS: decode = pwmirq_pkg::PWMIRQ_SEL_STATUS;
            `PWMIRQ_OFS_EVENT_CLEAR: decode = pwmirq_pkg::PWMIRQ_SEL_EVCLR;
            default: decode = pwmirq_pkg::PWMIRQ_SEL_NONE;
        endcase
    endfunction

    pwmirq_loop_if #(.LOOP_W(LOOP_W)) loop_bus ();

    pwmirq_loop_tracker #(.LOOP_W(LOOP_W)) u_loop (
        .ref_clk_i(ref_clk_i),
        .rstn_i(rstn_i),
        .lp(loop_bus.tracker)
    );

    assign loop_bus.start = playback_start_i;
    assign loop_bus.seq1_end = seq_finished_i[1];
    assign loop_bus.loop_cnt = loop_count_i;

    // write channel
    pwmirq_pkg::pwmirq_wr_state_type wr_state_ff;
    logic awready_ff;
    logic wready_ff;
    logic bvalid_ff;
    logic [1:0] bresp_ff;
    logic [11:0] waddr_ff;
    logic [31:0] wdata_ff;
    logic wlane0_ff;
    logic aw_have_ff;
    logic w_have_ff;
    logic aw_take;
    logic w_take;

    assign aw_take = s_axi_awvalid_i && awready_ff;
    assign w_take = s_axi_wvalid_i && wready_ff;

    // address and data are caught in either order, then applied once
    always_ff @(posedge ref_clk_i) begin
        if (!rstn_i) begin
            wr_state_ff <= pwmirq_pkg::PWMIRQ_WR_COLLECT;
            awready_ff <= 1'b1;
            wready_ff <= 1'b1;
            aw_have_ff <= 1'b0;
            w_have_ff <= 1'b0;
            waddr_ff <= 12'h000;
            wdata_ff <= 32'h00000000;
            wlane0_ff <= 1'b0;
            bvalid_ff <= 1'b0;
            bresp_ff <= `PWMIRQ_RESP_OKAY;
        end else begin
            unique case (wr_state_ff)
                pwmirq_pkg::PWMIRQ_WR_COLLECT: begin
                    if (aw_take) begin
                        waddr_ff <= s_axi_awaddr_i;
                        aw_have_ff <= 1'b1;
                        awready_ff <= 1'b0;
                    end
                    if (w_take) begin
                        wdata_ff <= s_axi_wdata_i;
                        wlane0_ff <= s_axi_wstrb_i[0];
                        w_have_ff <= 1'b1;
                        wready_ff <= 1'b0;
                    end
                    if ((aw_have_ff || aw_take) && (w_have_ff || w_take)) begin
                        wr_state_ff <= pwmirq_pkg::PWMIRQ_WR_APPLY;
                    end
                end
                pwmirq_pkg::PWMIRQ_WR_APPLY: begin
                    bvalid_ff <= 1'b1;
                    bresp_ff <= (decode(waddr_ff) == pwmirq_pkg::PWMIRQ_SEL_NONE) ?
                        `PWMIRQ_RESP_SLVERR : `PWMIRQ_RESP_OKAY;
                    wr_state_ff <= pwmirq_pkg::PWMIRQ_WR_RESP;
                end
                pwmirq_pkg::PWMIRQ_WR_RESP: begin
                    if (s_axi_bready_i) begin
                        bvalid_ff <= 1'b0;
                        aw_have_ff <= 1'b0;
                        w_have_ff <= 1'b0;
                        awready_ff <= 1'b1;
                        wready_ff <= 1'b1;
                        wr_state_ff <= pwmirq_pkg::PWMIRQ_WR_COLLECT;
                    end
                end
            endcase
        end
    end

    logic wr_apply;
    pwmirq_pkg::pwmirq_sel_type wr_sel;
    logic [EW-1:0] wr_bits;

    // only byte lane 0 carries enable bits; other lanes are ignored
    assign wr_apply = (wr_state_ff == pwmirq_pkg::PWMIRQ_WR_APPLY) && wlane0_ff;
    assign wr_sel = decode(waddr_ff);
    assign wr_bits = wdata_ff[EW-1:0] & `PWMIRQ_EVT_MASK;

    // enable bits
    logic [EW-1:0] enable_ff;
    logic [EW-1:0] nxt_enable;

    always_comb begin
        nxt_enable = enable_ff;
        if (wr_apply) begin
            unique case (wr_sel)
                pwmirq_pkg::PWMIRQ_SEL_DIRECT: nxt_enable = wr_bits;
                pwmirq_pkg::PWMIRQ_SEL_SET: nxt_enable = enable_ff | wr_bits;
                pwmirq_pkg::PWMIRQ_SEL_CLEAR: nxt_enable = enable_ff & ~wr_bits;
                default: nxt_enable = enable_ff;
            endcase
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rstn_i) begin
            enable_ff <= `PWMIRQ_ENABLE_RESET;
        end else begin
            enable_ff <= nxt_enable;
        end
    end

    // event status, sticky
    logic [EW-1:0] events;
    logic [EW-1:0] status_ff;
    logic [EW-1:0] nxt_status;

    always_comb begin
        events = '0;
        events[`PWMIRQ_BIT_STOPPED] = stopped_i;
        events[`PWMIRQ_BIT_SEQ_BEGAN0] = seq_began_i[0];
        events[`PWMIRQ_BIT_SEQ_BEGAN1] = seq_began_i[1];
        events[`PWMIRQ_BIT_SEQ_FINISHED0] = seq_finished_i[0];
        events[`PWMIRQ_BIT_SEQ_FINISHED1] = seq_finished_i[1];
        events[`PWMIRQ_BIT_PERIOD_FINISHED] = period_finished_i;
        events[`PWMIRQ_BIT_LOOPS_FINISHED] = loop_bus.loops_done;
    end

    // a new event beats a clear in the same cycle so it is never lost
    always_comb begin
        nxt_status = status_ff;
        if (wr_apply && wr_sel == pwmirq_pkg::PWMIRQ_SEL_EVCLR) begin
            nxt_status = status_ff & ~wr_bits;
        end
        nxt_status = nxt_status | events;
    end

    always_ff @(posedge ref_clk_i) begin
        if (!rstn_i) begin
            status_ff <= `PWMIRQ_STATUS_RESET;
        end else begin
            status_ff <= nxt_status;
        end
    end

    logic irq_ff;

    always_ff @(posedge ref_clk_i) begin
        if (!rstn_i) begin
            irq_ff <= 1'b0;
        end else begin
            irq_ff <= |(nxt_status & nxt_enable);
        end
    end

    // read channel
    pwmirq_pkg::pwmirq_rd_state_type rd_state_ff;
    logic arready_ff;
    logic rvalid_ff;
    logic [31:0] rdata_ff;
    logic [1:0] rresp_ff;
    pwmirq_pkg::pwmirq_sel_type rd_sel;

    assign rd_sel = decode(s_axi_araddr_i);

    always_ff @(posedge ref_clk_i) begin
        if (!rstn_i) begin
            rd_state_ff <= pwmirq_pkg::PWMIRQ_RD_IDLE;
            arready_ff <= 1'b1;
            rvalid_ff <= 1'b0;
            rdata_ff <= 32'h00000000;
            rresp_ff <= `PWMIRQ_RESP_OKAY;
        end else begin
            unique case (rd_state_ff)
                pwmirq_pkg::PWMIRQ_RD_IDLE: begin
                    if (s_axi_arvalid_i) begin
                        arready_ff <= 1'b0;
                        rvalid_ff <= 1'b1;
                        rresp_ff <= `PWMIRQ_RESP_OKAY;
                        rdata_ff <= 32'h00000000;
                        unique case (rd_sel)
                            pwmirq_pkg::PWMIRQ_SEL_DIRECT,
                            pwmirq_pkg::PWMIRQ_SEL_SET,
                            pwmirq_pkg::PWMIRQ_SEL_CLEAR: rdata_ff[EW-1:0] <= enable_ff;
                            pwmirq_pkg::PWMIRQ_SEL_STATUS: rdata_ff[EW-1:0] <= status_ff;
                            // the event clear register is write only
                            pwmirq_pkg::PWMIRQ_SEL_EVCLR: rdata_ff <= 32'h00000000;
                            default: rresp_ff <= `PWMIRQ_RESP_SLVERR;
                        endcase
                        rd_state_ff <= pwmirq_pkg::PWMIRQ_RD_RESP;
                    end
                end
                pwmirq_pkg::PWMIRQ_RD_RESP: begin
                    if (s_axi_rready_i) begin
                        rvalid_ff <= 1'b0;
                        arready_ff <= 1'b1;
                        rd_state_ff <= pwmirq_pkg::PWMIRQ_RD_IDLE;
                    end
                end
            endcase
        end
    end

    assign s_axi_awready_o = awready_ff;
    assign s_axi_wready_o = wready_ff;
    assign s_axi_bvalid_o = bvalid_ff;
    assign s_axi_bresp_o = bresp_ff;
    assign s_axi_arready_o = arready_ff;
    assign s_axi_rvalid_o = rvalid_ff;
    assign s_axi_rdata_o = rdata_ff;
    assign s_axi_rresp_o = rresp_ff;
    assign irq_enable_o = enable_ff;
    assign irq_o = irq_ff;
endmodule

// >>> verification/pwmirq_evt_model.sv
// event source standing in for the pulse generator core
`timescale 1ns/1ps
module pwmirq_evt_model (
    input wire logic ref_clk_i, // clock
    output logic [7:0] evt_o, // event pulses by enable bit
    output logic start_o, // playback start pulse
    output logic [15:0] loops_o // loop count with start
);
    initial begin
        evt_o = 8'h00;
        start_o = 1'b0;
        loops_o = 16'hFFFF;
    end
    task automatic pulse(input int n);
        @(posedge ref_clk_i);
        evt_o <= 8'h01 << n;
        @(posedge ref_clk_i);
        evt_o <= 8'h00;
    endtask
    task automatic start(input logic [15:0] n);
        @(posedge ref_clk_i);
        start_o <= 1'b1;
        loops_o <= n;
        @(posedge ref_clk_i);
        start_o <= 1'b0;
        // count is only meaningful beside the start pulse
        loops_o <= ~n;
    endtask
endmodule

// >>> verification/pwmirq_sva.sv
// port assertions for the pwm interrupt enable block
`timescale 1ns/1ps
module pwmirq_sva (
    input wire logic ref_clk_i, // clock
    input wire logic rstn_i, // reset
    input wire logic [11:0] s_axi_awaddr_i, // waddr
    input wire logic s_axi_awvalid_i, // aw valid
    input wire logic s_axi_awready_o, // aw ready
    input wire logic [31:0] s_axi_wdata_i, // wdata
    input wire logic [3:0] s_axi_wstrb_i, // strobes
    input wire logic s_axi_wvalid_i, // w valid
    input wire logic s_axi_wready_o, // w ready
    input wire logic [1:0] s_axi_bresp_o, // bresp
    input wire logic s_axi_bvalid_o, // b valid
    input wire logic s_axi_bready_i, // b ready
    input wire logic s_axi_arvalid_i, // ar valid
    input wire logic s_axi_arready_o, // ar ready
    input wire logic [31:0] s_axi_rdata_o, // rdata
    input wire logic s_axi_rvalid_o, // r valid
    input wire logic s_axi_rready_i, // r ready
    input wire logic stopped_i, // stop event
    input wire logic [7:0] irq_enable_o, // enables
    input wire logic irq_o // request
);
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!rstn_i);
    logic take;
    logic [7:0] wmask;
    logic [11:0] wa_ff;
    logic [7:0] wm_ff;
    logic [7:0] en_ff;
    assign take = s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o;
    assign wmask = s_axi_wdata_i[7:0] & 8'hFE & {8{s_axi_wstrb_i[0]}};
    // judged at the response, since that is when the enables land
    always_ff @(posedge ref_clk_i) begin
        if (!rstn_i) begin
            wa_ff <= 12'h000;
            wm_ff <= 8'h00;
            en_ff <= 8'h00;
        end else if (take) begin
            wa_ff <= s_axi_awaddr_i;
            wm_ff <= wmask;
            en_ff <= irq_enable_o;
        end
    end
    property p_set;
        $rose(s_axi_bvalid_o) && wa_ff == 12'h304 |-> irq_enable_o == (en_ff | wm_ff);
    endproperty
    a_set: assert property (p_set) else $error("set write result wrong");
    property p_clr;
        $rose(s_axi_bvalid_o) && wa_ff == 12'h308 |-> irq_enable_o == (en_ff & ~wm_ff);
    endproperty
    a_clr: assert property (p_clr) else $error("clear write result wrong");
    property p_wr_lat;
        take |-> ##[1:3] s_axi_bvalid_o;
    endproperty
    a_wr_lat: assert property (p_wr_lat) else $error("write response late");
    property p_rd_lat;
        s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o && !s_axi_arready_o;
    endproperty
    a_rd_lat: assert property (p_rd_lat) else $error("read response late");
    property p_b_hold;
        s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o && $stable(s_axi_bresp_o);
    endproperty
    a_b_hold: assert property (p_b_hold) else $error("write response dropped");
    property p_r_hold;
        s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && $stable(s_axi_rdata_o);
    endproperty
    a_r_hold: assert property (p_r_hold) else $error("read data dropped");
    property p_irq_en;
        irq_o |-> irq_enable_o != 8'h00;
    endproperty
    a_irq_en: assert property (p_irq_en) else $error("request with no enable");
    property p_irq_stop;
        stopped_i && irq_enable_o[1] |=> irq_o || !irq_enable_o[1];
    endproperty
    a_irq_stop: assert property (p_irq_stop) else $error("stop event lost");
    property p_bit0;
        irq_enable_o[0] == 1'b0;
    endproperty
    a_bit0: assert property (p_bit0) else $error("unused enable bit set");
    c_set: cover property ($rose(s_axi_bvalid_o) && wa_ff == 12'h304);
    c_clr: cover property ($rose(s_axi_bvalid_o) && wa_ff == 12'h308);
    c_irq: cover property ($rose(irq_o));
endmodule
bind pwmirq_top pwmirq_sva u_sva (.*);

// >>> verification/pwmirq_top_tb.sv
// self-checking bench for the pwm interrupt enable block
`timescale 1ns/1ps
`include "pwmirq_regs.svh"
module pwmirq_top_tb;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic [11:0] awaddr = 12'h000;
    logic [11:0] araddr = 12'h000;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'hF;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, irq, start;
    logic [1:0] bresp, rresp, rs;
    logic [31:0] rdata, rd;
    logic [7:0] en, evt, exp_en;
    logic [15:0] loops;
    int fail_count = 0, check_count = 0, cyc = 0;
    initial forever #20 clk = ~clk;
    pwmirq_top dut (.ref_clk_i(clk), .rstn_i(rstn), .s_axi_awaddr_i(awaddr),
        .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
        .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready),
        .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
        .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready),
        .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
        .s_axi_rready_i(rready), .stopped_i(evt[1]), .seq_began_i(evt[3:2]),
        .seq_finished_i(evt[5:4]), .period_finished_i(evt[6]), .playback_start_i(start),
        .loop_count_i(loops), .irq_enable_o(en), .irq_o(irq));
    pwmirq_evt_model u_evt (.ref_clk_i(clk), .evt_o(evt), .start_o(start), .loops_o(loops));
    task automatic results();
        if (fail_count == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            fail_count++;
            $display("BAD %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic ta;
        logic tw;
        ta = 1'b0;
        tw = 1'b0;
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        while (!(ta && tw)) begin
            @(posedge clk);
            if (awvalid && awready) begin
                ta = 1'b1;
                awvalid <= 1'b0;
            end
            if (wvalid && wready) begin
                tw = 1'b1;
                wvalid <= 1'b0;
            end
        end
        bready <= 1'b1;
        do @(posedge clk); while (!bvalid);
        rs = bresp;
        bready <= 1'b0;
    endtask
    task automatic rd_reg(input logic [11:0] a);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge clk); while (!arready);
        arvalid <= 1'b0;
        do @(posedge clk); while (!rvalid);
        rd = rdata;
        rs = rresp;
        rready <= 1'b0;
    endtask
    task automatic irq_after(input int n, input logic exp);
        repeat (n) @(posedge clk);
        chk({31'h0, irq}, {31'h0, exp});
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 4000) begin
            fail_count++;
            results();
        end
    end
    initial begin
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        rd_reg(`PWMIRQ_OFS_ENABLE_CLEAR);
        chk(rd, 32'h0);
        exp_en = 8'h00;
        for (int i = 0; i < 8; i++) begin
            wr(`PWMIRQ_OFS_ENABLE_SET, 32'h1 << i);
            exp_en = exp_en | (8'h01 << i) & 8'hFE;
            rd_reg(`PWMIRQ_OFS_ENABLE_SET);
            chk(rd, {24'h0, exp_en});
        end
        for (int i = 1; i < 8; i++) begin
            wr(`PWMIRQ_OFS_ENABLE_CLEAR, 32'h1 << i);
            rd_reg(`PWMIRQ_OFS_ENABLE_CLEAR);
            chk(rd, {24'h0, 8'hFE & ~(8'h01 << i)});
            wr(`PWMIRQ_OFS_ENABLE_SET, 32'h1 << i);
        end
        wr(`PWMIRQ_OFS_ENABLE_CLEAR, 32'h0);
        wstrb <= 4'h0;
        wr(`PWMIRQ_OFS_ENABLE_CLEAR, 32'hFF);
        chk({30'h0, rs}, {30'h0, `PWMIRQ_RESP_OKAY});
        wstrb <= 4'hF;
        rd_reg(`PWMIRQ_OFS_ENABLE_SET);
        chk(rd, 32'hFE);
        wr(`PWMIRQ_OFS_ENABLE_DIRECT, 32'h0F);
        rd_reg(`PWMIRQ_OFS_ENABLE_SET);
        chk(rd, 32'h0E);
        wr(`PWMIRQ_OFS_ENABLE_DIRECT, 32'h0);
        for (int i = 1; i < 7; i++) begin
            u_evt.pulse(i);
            irq_after(1, 1'b0);
            wr(`PWMIRQ_OFS_ENABLE_SET, 32'h1 << i);
            irq_after(0, 1'b1);
            wr(`PWMIRQ_OFS_EVENT_CLEAR, 32'h1 << i);
            irq_after(0, 1'b0);
            u_evt.pulse(i);
            irq_after(1, 1'b1);
            wr(`PWMIRQ_OFS_ENABLE_CLEAR, 32'h1 << i);
            irq_after(0, 1'b0);
            wr(`PWMIRQ_OFS_EVENT_CLEAR, 32'hFF);
        end
        wr(`PWMIRQ_OFS_ENABLE_DIRECT, 32'h80);
        u_evt.start(16'h0002);
        u_evt.pulse(5);
        irq_after(4, 1'b0);
        u_evt.pulse(5);
        irq_after(4, 1'b1);
        rd_reg(`PWMIRQ_OFS_EVENT_STATUS);
        chk(rd, 32'hA0);
        wr(`PWMIRQ_OFS_EVENT_CLEAR, 32'hFF);
        u_evt.start(16'h0000);
        u_evt.pulse(5);
        u_evt.pulse(5);
        irq_after(4, 1'b0);
        // mid-run reset must drop enables and the request
        @(posedge clk);
        rstn <= 1'b0;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
        rd_reg(`PWMIRQ_OFS_ENABLE_SET);
        chk(rd, 32'h0);
        irq_after(0, 1'b0);
        // upper lanes carry no enables
        wstrb <= 4'hE;
        wr(`PWMIRQ_OFS_ENABLE_SET, 32'hFF);
        rd_reg(`PWMIRQ_OFS_ENABLE_SET);
        chk(rd, 32'h0);
        wstrb <= 4'h1;
        wr(`PWMIRQ_OFS_ENABLE_SET, 32'h06);
        rd_reg(`PWMIRQ_OFS_ENABLE_CLEAR);
        chk(rd, 32'h06);
        wstrb <= 4'hF;
        wr(12'h400, 32'hFF);
        chk({30'h0, rs}, {30'h0, `PWMIRQ_RESP_SLVERR});
        rd_reg(12'h400);
        chk(rd, 32'h0);
        chk({30'h0, rs}, {30'h0, `PWMIRQ_RESP_SLVERR});
        results();
    end
endmodule
